/* File: core/irq_wake_ctrl.sv */
`timescale 1ns/10ps
module irq_wake_ctrl
  import irq_wake_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire wb_req_t wb_req_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Event sources
  input wire logic [7:0] src_event_i,
  input wire logic ext_pin_i,
  input wire logic port_change_i,
  input wire logic timer_wake_i,
  // Core sequencer
  input wire logic int_take_i,
  input wire logic return_from_interrupt_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire cpu_ctx_t ctx_i,
  output logic irq_o,
  output logic [7:0] vector_o,
  output cpu_ctx_t ctx_o,
  // Operating mode
  output logic run_o,
  output logic power_down_o,
  output logic idle_o,
  output logic slow_o
);

  logic ack_q;
  logic [DAT_W-1:0] rdat_q;
  logic [7:0] req_flags_q;
  logic [7:0] req_flags_d;
  logic [7:0] enables_q;
  logic [1:0] pin_edge_field_q;
  logic global_int_enable_q;
  logic [2:0] stack_pointer_bits_q;
  logic [2:0] mode_q;
  pmode_t state_q;
  pmode_t state_d;
  logic [5:0] wake_cnt_q;
  cpu_ctx_t save_q;
  logic irq_q;
  logic [7:0] vector_q;
  cpu_ctx_t ctx_q;
  logic run_q;
  logic pd_q;
  logic idle_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  logic port_s1_q;
  logic port_s2_q;
  logic access;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic wr_flags;
  logic pin_rise;
  logic pin_fall;
  logic pin_hit;
  logic [7:0] set_vec;
  logic take;
  logic pd_exit;
  logic idle_exit;
  logic [DAT_W-1:0] rdat_d;

  // Bus decode
  assign access = wb_req_i.cyc && wb_req_i.stb && !ack_q;
  assign wr = access && wb_req_i.we && wb_req_i.sel[0];
  assign idx = wb_req_i.adr[ADR_W-1:2];
  assign wbyte = wb_req_i.dat[7:0];
  assign wr_flags = wr && (idx == IDX_REQ_FLAGS);

  // Pin and port synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
      port_s1_q <= 1'b0;
      port_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= ext_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      port_s1_q <= port_change_i;
      port_s2_q <= port_s1_q;
    end
  end

  // Edge qualification by the select field
  assign pin_rise = pin_s2_q && !pin_s3_q;
  assign pin_fall = !pin_s2_q && pin_s3_q;
  always_comb begin
    case (pin_edge_field_q)
      EDGE_RISE: pin_hit = pin_rise;
      EDGE_FALL: pin_hit = pin_fall;
      EDGE_BOTH: pin_hit = pin_rise || pin_fall;
      default: pin_hit = 1'b0;
    endcase
  end

  // Event vector: six internal sources plus the pin
  always_comb begin
    set_vec = src_event_i & SRC_MASK;
    set_vec[BIT_PIN] = pin_hit;
  end

  // Request flags: software writes, hardware set wins
  always_comb begin
    req_flags_d = req_flags_q;
    if (wr_flags) begin
      req_flags_d = wbyte;
    end
    req_flags_d = (req_flags_d | set_vec) & SRC_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_flags_q <= FLAGS_RST;
    end else begin
      req_flags_q <= req_flags_d;
    end
  end

  // Enables and edge select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enables_q <= ENABLES_RST;
      pin_edge_field_q <= EDGE_RST;
    end else if (wr) begin
      if (idx == IDX_ENABLES) begin
        enables_q <= wbyte & SRC_MASK;
      end else if (idx == IDX_PIN_EDGE) begin
        pin_edge_field_q <= wbyte[EDGE_LO +: 2];
      end
    end
  end

  // Interrupt take is honoured only while a request stands
  assign take = int_take_i && irq_q;

  // Global enable and stack level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_int_enable_q <= GIE_RST;
      stack_pointer_bits_q <= STACK_RST;
    end else if (take) begin
      global_int_enable_q <= 1'b0;
      stack_pointer_bits_q <= stack_pointer_bits_q - 3'h1;
    end else if (return_from_interrupt_i) begin
      global_int_enable_q <= 1'b1;
      stack_pointer_bits_q <= stack_pointer_bits_q + 3'h1;
    end else if (wr && (idx == IDX_STACK)) begin
      global_int_enable_q <= wbyte[GIE_BIT];
      stack_pointer_bits_q <= wbyte[2:0];
    end
  end

  // Request to the core and vector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
      vector_q <= VECTOR_ADDR;
    end else begin
      irq_q <= (state_d == ST_RUN) && global_int_enable_q && !take
               && |(req_flags_q & enables_q);
      if (take) begin
        vector_q <= VECTOR_ADDR;
      end
    end
  end

  // One-level save buffer for accumulator and flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      save_q <= '0;
      ctx_q <= '0;
    end else begin
      if (push_i) begin
        save_q.accumulator <= ctx_i.accumulator;
        save_q.processor_flags <= ctx_i.processor_flags & ~FLAG_HOLD_MASK;
      end
      if (pop_i) begin
        ctx_q.accumulator <= save_q.accumulator;
        ctx_q.processor_flags <= (save_q.processor_flags & ~FLAG_HOLD_MASK)
                                 | (ctx_i.processor_flags & FLAG_HOLD_MASK);
      end
    end
  end

  // Mode sequencer
  assign pd_exit = (state_q == ST_WARMUP) && (wake_cnt_q == 6'h0);
  assign idle_exit = (state_q == ST_IDLE) && (port_s2_q || timer_wake_i);
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (mode_q[MODE_PD_BIT]) begin
          state_d = ST_POWER_DOWN;
        end else if (mode_q[MODE_IDLE_BIT]) begin
          state_d = ST_IDLE;
        end
      end
      ST_POWER_DOWN: begin
        if (port_s2_q) begin
          state_d = ST_WARMUP;
        end
      end
      ST_WARMUP: begin
        if (pd_exit) begin
          state_d = ST_RUN;
        end
      end
      ST_IDLE: begin
        if (idle_exit) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_RUN;
      wake_cnt_q <= WAKE_LOAD;
    end else begin
      state_q <= state_d;
      if (state_q == ST_POWER_DOWN) begin
        wake_cnt_q <= WAKE_LOAD;
      end else if (state_q == ST_WARMUP) begin
        wake_cnt_q <= wake_cnt_q - 6'h1;
      end
    end
  end

  // Mode control register; hardware clears requests on wake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_RST;
    end else if (pd_exit) begin
      mode_q[MODE_PD_BIT] <= 1'b0;
      mode_q[MODE_SLOW_BIT] <= 1'b0;
    end else if (idle_exit) begin
      mode_q[MODE_IDLE_BIT] <= 1'b0;
    end else if (wr && (idx == IDX_MODE)) begin
      mode_q <= wbyte[2:0];
    end
  end

  // Mode outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 1'b1;
      pd_q <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      run_q <= (state_d == ST_RUN);
      pd_q <= (state_d == ST_POWER_DOWN) || (state_d == ST_WARMUP);
      idle_q <= (state_d == ST_IDLE);
    end
  end

  // Read mux; unmapped reads give zero
  always_comb begin
    rdat_d = '0;
    if (idx == IDX_REQ_FLAGS) begin
      rdat_d[7:0] = req_flags_q;
    end else if (idx == IDX_ENABLES) begin
      rdat_d[7:0] = enables_q;
    end else if (idx == IDX_PIN_EDGE) begin
      rdat_d[EDGE_LO +: 2] = pin_edge_field_q;
    end else if (idx == IDX_STACK) begin
      rdat_d[GIE_BIT] = global_int_enable_q;
      rdat_d[2:0] = stack_pointer_bits_q;
    end else if (idx == IDX_MODE) begin
      rdat_d[2:0] = mode_q;
    end else if (idx == IDX_SAVE_ACC) begin
      rdat_d[7:0] = save_q.accumulator;
    end else if (idx == IDX_SAVE_FLAGS) begin
      rdat_d[7:0] = save_q.processor_flags;
    end
  end

  // Single-wait acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= access;
      if (access) begin
        rdat_q <= rdat_d;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign irq_o = irq_q;
  assign vector_o = vector_q;
  assign ctx_o = ctx_q;
  assign run_o = run_q;
  assign power_down_o = pd_q;
  assign idle_o = idle_q;
  assign slow_o = mode_q[MODE_SLOW_BIT];

  // Checking helpers
  logic [6:0] warm_len_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != ST_WARMUP) begin
      warm_len_q <= 7'h0;
    end else begin
      warm_len_q <= warm_len_q + 7'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_GIE_CLEAR_ON_TAKE: assert property (
    take |=> !global_int_enable_q && !irq_o)
    else $error("global enable not cleared after take");
  AST_GIE_SET_ON_RETURN_FROM_INTERRUPT: assert property (
    return_from_interrupt_i && !take |=> global_int_enable_q)
    else $error("global enable not set by return");
  AST_STACK_LEVEL: assert property (
    take |=> stack_pointer_bits_q == $past(stack_pointer_bits_q) - 3'h1
             && vector_o == VECTOR_ADDR)
    else $error("stack level or vector wrong on take");
  AST_IRQ_CAUSE: assert property (
    irq_o |-> $past(global_int_enable_q) && $past(|(req_flags_q & enables_q)))
    else $error("request without enabled flag and global enable");
  AST_SET_WINS: assert property (
    set_vec != 8'h00 |=> (req_flags_q & $past(set_vec)) == $past(set_vec))
    else $error("event lost against a clear");
  AST_NO_SELF_CLEAR: assert property (
    (|($past(req_flags_q) & ~req_flags_q)) |-> $past(wr_flags))
    else $error("flag cleared without software write");
  AST_WARMUP_LEN: assert property (
    $fell(state_q == ST_WARMUP) |-> $past(warm_len_q) == 7'(WAKE_CYCLES - 1))
    else $error("warm-up length differs from the wake count");
  AST_PD_WAKE_NORMAL: assert property (
    $fell(state_q == ST_WARMUP) |-> state_q == ST_RUN && !slow_o)
    else $error("power-down wake did not resume in normal mode");
  AST_PD_BIT_CLEARED: assert property (
    $fell(state_q == ST_WARMUP) |-> !mode_q[MODE_PD_BIT])
    else $error("power-down request not cleared on wake");
  AST_IDLE_NO_DELAY: assert property (
    idle_exit |=> state_q == ST_RUN ##1 run_o)
    else $error("idle wake delayed");
  AST_BIT1_UNUSED: assert property (
    !req_flags_q[1] && !enables_q[1])
    else $error("unused bit one became set");
  AST_PIN_FLAG: assert property (
    pin_hit |=> req_flags_q[BIT_PIN])
    else $error("qualified pin edge did not set its flag");

  COV_TAKE: cover property (take ##[1:20] return_from_interrupt_i);
  COV_PD_WAKE: cover property ($fell(state_q == ST_WARMUP));
  COV_IDLE_WAKE: cover property (idle_exit && timer_wake_i);
  COV_SET_VS_CLEAR: cover property (wr_flags && set_vec != 8'h00);

endmodule

/* File: core/irq_wake_pkg.sv */
package irq_wake_pkg;
  // Bus geometry
  localparam int ADR_W = 10;
  localparam int DAT_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_PIN_EDGE = 8'hbf;
  localparam logic [7:0] IDX_REQ_FLAGS = 8'hc8;
  localparam logic [7:0] IDX_ENABLES = 8'hc9;
  localparam logic [7:0] IDX_MODE = 8'hca;
  localparam logic [7:0] IDX_SAVE_ACC = 8'hcb;
  localparam logic [7:0] IDX_SAVE_FLAGS = 8'hcc;
  localparam logic [7:0] IDX_STACK = 8'hdf;
  // Source bit positions, shared by flags and enables
  localparam int BIT_PIN = 0;
  localparam int BIT_TIMER_B = 2;
  localparam int BIT_SERIAL = 3;
  localparam int BIT_TIMER_A = 4;
  localparam int BIT_COUNTER_A = 5;
  localparam int BIT_COUNTER_B = 6;
  localparam int BIT_COMPARATOR = 7;
  localparam logic [7:0] SRC_MASK = 8'hfd;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ENABLES_RST = 8'h00;
  // Stack register layout
  localparam int GIE_BIT = 7;
  localparam logic GIE_RST = 1'b0;
  localparam logic [2:0] STACK_RST = 3'h7;
  // Pin edge select field
  localparam int EDGE_LO = 3;
  localparam logic [1:0] EDGE_RST = 2'h2;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Mode control bits
  localparam int MODE_PD_BIT = 0;
  localparam int MODE_IDLE_BIT = 1;
  localparam int MODE_SLOW_BIT = 2;
  localparam logic [2:0] MODE_RST = 3'h0;
  // Processor flag bits kept out of the save buffer
  localparam logic [7:0] FLAG_HOLD_MASK = 8'hc0;
  // Vector and wake-up timing
  localparam logic [7:0] VECTOR_ADDR = 8'h08;
  localparam int WAKE_HOSC_CLOCKS = 32;
  localparam int WAKE_CYCLES = WAKE_HOSC_CLOCKS;
  localparam logic [5:0] WAKE_LOAD = 6'(WAKE_CYCLES - 1);

  typedef enum logic [1:0] {ST_RUN, ST_POWER_DOWN, ST_WARMUP, ST_IDLE} pmode_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [DAT_W-1:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [7:0] accumulator;
    logic [7:0] processor_flags;
  } cpu_ctx_t;
endpackage

/* File: tb/core_seq_model.sv */
`timescale 1ns/10ps
module core_seq_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Controller side
  input wire logic irq_i,
  output logic int_take_o = 1'b0,
  output logic return_from_interrupt_o = 1'b0,
  // Bench control
  input wire logic arm_i,
  input wire logic [3:0] lag_i
);
  logic [5:0] cnt_q = 6'h00;
  logic busy_q = 1'b0;
  // Take after a lag, serve for 40 cycles, then return
  always @(posedge clk_i) begin
    int_take_o <= 1'b0;
    return_from_interrupt_o <= 1'b0;
    if (rst_i) begin
      busy_q <= 1'b0;
      cnt_q <= 6'h00;
    end else if (!busy_q) begin
      if (arm_i && irq_i && cnt_q >= {2'h0, lag_i}) begin
        int_take_o <= 1'b1;
        busy_q <= 1'b1;
        cnt_q <= 6'h00;
      end else begin
        cnt_q <= (arm_i && irq_i) ? cnt_q + 6'h01 : 6'h00;
      end
    end else if (cnt_q == 6'h28) begin
      return_from_interrupt_o <= 1'b1;
      busy_q <= 1'b0;
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
endmodule

/* File: tb/interrupt_and_wakeup_control_test.sv */
`timescale 1ns/10ps
module interrupt_and_wakeup_control_test;
  import irq_wake_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, ext_pin_i = 1'b0, port_change_i = 1'b0;
  logic timer_wake_i = 1'b0, push_i = 1'b0, pop_i = 1'b0, arm = 1'b0;
  logic int_take_i, return_from_interrupt_i, wb_ack_o, irq_o, run_o, power_down_o, idle_o, slow_o;
  logic [7:0] src_event_i = 8'h00, vector_o, v;
  logic [3:0] lag = 4'h0;
  logic [DAT_W-1:0] wb_dat_o;
  logic [31:0] exp_q[$];
  wb_req_t wb_req = '0;
  cpu_ctx_t ctx_i = '0, ctx_o, sv;
  int err_total = 0, checks_done = 0, n;

  always #50 clk_i = ~clk_i;

  irq_wake_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .src_event_i(src_event_i), .ext_pin_i(ext_pin_i),
    .port_change_i(port_change_i), .timer_wake_i(timer_wake_i), .int_take_i(int_take_i),
    .return_from_interrupt_i(return_from_interrupt_i), .push_i(push_i), .pop_i(pop_i), .ctx_i(ctx_i), .irq_o(irq_o),
    .vector_o(vector_o), .ctx_o(ctx_o), .run_o(run_o), .power_down_o(power_down_o),
    .idle_o(idle_o), .slow_o(slow_o));

  core_seq_model core (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_o), .int_take_o(int_take_i),
    .return_from_interrupt_o(return_from_interrupt_i), .arm_i(arm), .lag_i(lag));

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic tick(int k);
    repeat (k) @(posedge clk_i);
  endtask

  // One classic cycle; ev pulses events at the edge the request is taken
  task automatic bus(logic we, logic [7:0] idx, logic [7:0] d, logic [7:0] ev = 8'h00);
    int k = 0;
    wb_req <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'h1, {24'h000000, d}};
    src_event_i <= ev;
    @(posedge clk_i);
    src_event_i <= 8'h00;
    while (wb_ack_o !== 1'b1 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 20) chk("ack", 32'h1, 32'h0);
    wb_req <= '0;
    @(posedge clk_i);
  endtask

  task automatic wr(logic [7:0] idx, logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(logic [7:0] idx, logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, idx, 8'h00);
  endtask

  // Wait for take, return or run, counting edges
  task automatic await(int w, int lim);
    n = 0;
    while ((w == 0 ? int_take_i : w == 1 ? return_from_interrupt_i : run_o) !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) chk("wait", 32'h1, 32'h0);
  endtask

  task automatic pulse_timer();
    timer_wake_i <= 1'b1;
    tick(1);
    timer_wake_i <= 1'b0;
  endtask

  // Read data compared against the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_req.we === 1'b0) begin
      if (exp_q.size() == 0) chk("spare ack", 32'h0, 32'h1);
      else chk("read data", exp_q.pop_front(), wb_dat_o);
    end
  end

  // Watchdog
  initial begin
    #2000000;
    chk("timeout", 32'h0, 32'h1);
    end_of_test();
  end

  initial begin
    v = 8'($urandom(32'he6d841f8));
    tick(16);
    rst_i <= 1'b0;
    tick(1);
    chk("vector", VECTOR_ADDR, vector_o);
    chk("run", 32'h1, run_o);
    rd(IDX_PIN_EDGE, 32'h10);
    rd(IDX_REQ_FLAGS, 32'h0);
    rd(IDX_ENABLES, 32'h0);
    rd(IDX_STACK, 32'h07);
    rd(8'hff, 32'h0);
    v = 8'($urandom());
    wr(IDX_ENABLES, v);
    rd(IDX_ENABLES, v & SRC_MASK);
    wr(IDX_ENABLES, 8'h00);
    // Internal events, each also racing a software clear
    for (int b = 2; b < 8; b++) begin
      bus(1'b1, IDX_REQ_FLAGS, 8'h00, 8'h01 << b);
      tick(4);
      chk("irq disabled", 32'h0, irq_o);
      rd(IDX_REQ_FLAGS, 32'h1 << b);
      rd(IDX_REQ_FLAGS, 32'h1 << b);
      wr(IDX_REQ_FLAGS, 8'h00);
      rd(IDX_REQ_FLAGS, 32'h0);
    end
    // Global enable gates a pending request
    lag = 4'($urandom_range(0, 9));
    arm <= 1'b1;
    wr(IDX_ENABLES, 8'h10);
    src_event_i <= 8'h10;
    tick(1);
    src_event_i <= 8'h00;
    tick(4);
    chk("irq no gie", 32'h0, irq_o);
    wr(IDX_STACK, 8'h87);
    chk("irq", 32'h1, irq_o);
    await(0, 40);
    tick(1);
    chk("irq taken", 32'h0, irq_o);
    chk("vector taken", VECTOR_ADDR, vector_o);
    rd(IDX_STACK, 32'h06);
    wr(IDX_REQ_FLAGS, 8'h00);
    await(1, 80);
    tick(1);
    rd(IDX_STACK, 32'h87);
    // Edge select modes on the pin
    wr(IDX_ENABLES, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(IDX_PIN_EDGE, 8'(m << EDGE_LO));
      rd(IDX_PIN_EDGE, 32'(m << EDGE_LO));
      wr(IDX_REQ_FLAGS, 8'h00);
      ext_pin_i <= 1'b1;
      tick(6);
      rd(IDX_REQ_FLAGS, 32'(m == 1 || m == 3));
      wr(IDX_REQ_FLAGS, 8'h00);
      ext_pin_i <= 1'b0;
      tick(6);
      rd(IDX_REQ_FLAGS, 32'(m >= 2));
    end
    // Power down, woken by a port change alongside a falling pin edge
    wr(IDX_PIN_EDGE, 8'h10);
    ext_pin_i <= 1'b1;
    tick(6);
    wr(IDX_REQ_FLAGS, 8'h00);
    wr(IDX_ENABLES, 8'h01);
    wr(IDX_MODE, 8'h05);
    tick(2);
    chk("pd", 32'h1, power_down_o);
    pulse_timer();
    tick(5);
    chk("pd timer", 32'h0, run_o);
    ext_pin_i <= 1'b0;
    port_change_i <= 1'b1;
    await(2, 60);
    chk("warmup", 32'h1, 32'(n >= 32 && n <= 40));
    await(0, 20);
    tick(1);
    port_change_i <= 1'b0;
    chk("slow after pd", 32'h0, slow_o);
    rd(IDX_MODE, 32'h0);
    wr(IDX_REQ_FLAGS, 8'h00);
    await(1, 80);
    // Idle, woken by timer then by port change
    wr(IDX_MODE, 8'h04);
    wr(IDX_MODE, 8'h06);
    tick(2);
    chk("idle", 32'h1, idle_o);
    pulse_timer();
    await(2, 10);
    chk("idle wake fast", 32'h1, 32'(n <= 4));
    chk("slow kept", 32'h1, slow_o);
    wr(IDX_MODE, 8'h02);
    tick(2);
    port_change_i <= 1'b1;
    await(2, 10);
    chk("idle port wake", 32'h1, 32'(n <= 5));
    chk("normal kept", 32'h0, slow_o);
    port_change_i <= 1'b0;
    // Save and restore
    sv = 16'($urandom());
    ctx_i <= sv;
    push_i <= 1'b1;
    tick(1);
    push_i <= 1'b0;
    ctx_i <= ~sv;
    pop_i <= 1'b1;
    tick(1);
    pop_i <= 1'b0;
    tick(1);
    chk("ctx acc", sv.accumulator, ctx_o.accumulator);
    chk("ctx flags", {~sv[7:6], sv[5:0]}, ctx_o.processor_flags);
    rd(IDX_SAVE_ACC, sv.accumulator);
    rd(IDX_SAVE_FLAGS, sv.processor_flags & 8'h3f);
    tick(2);
    chk("reads left", 32'h0, exp_q.size());
    end_of_test();
  end
endmodule
